// File: pkg/acq_timing_cfg.svh
// timing constants and output routing codes for acquisition sequencing
`ifndef ACQ_TIMING_CFG_SVH
`define ACQ_TIMING_CFG_SVH

`define ACQ_CLK_HZ 100000000
`define ACQ_CLK_PERIOD_NS 10
`define ACQ_CYC_PER_US 100
`define ACQ_START_DELAY_NS 180000
`define ACQ_LINE_TIME_NS 25210
`define ACQ_READ_OVERHEAD_NS 1623000
`define ACQ_PKT_TIME_NS 125000
`define ACQ_TX_TAIL_NS 250000
`define ACQ_PKT_CYC ((`ACQ_PKT_TIME_NS + `ACQ_CLK_PERIOD_NS - 1) / `ACQ_CLK_PERIOD_NS)
`define ACQ_TX_TAIL_CYC ((`ACQ_TX_TAIL_NS + `ACQ_CLK_PERIOD_NS - 1) / `ACQ_CLK_PERIOD_NS)
`define ACQ_ROUTE_OFF 2'h0
`define ACQ_ROUTE_EXPOSURE 2'h1
`define ACQ_ROUTE_PERMIT 2'h2
`define ACQ_ROUTE_TX 2'h3
`define ACQ_LINE1_RESET `ACQ_ROUTE_EXPOSURE
`define ACQ_LINE2_RESET `ACQ_ROUTE_PERMIT

`endif

// File: pkg/acq_timing_pkg.sv
// types shared by the acquisition sequencing logic
package acq_timing_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_DELAY = 4'h2,
		ST_EXPOSE = 4'h4,
		ST_READOUT = 4'h8
	} acq_state_t;

	typedef enum logic [3:0] {
		TX_IDLE = 4'h1,
		TX_FILL = 4'h2,
		TX_SEND = 4'h4,
		TX_TAIL = 4'h8
	} tx_state_t;
endpackage : acq_timing_pkg

// File: hdl/ceil_divider.sv
// sequential divider returning the quotient rounded up
`timescale 1ns/100ps
`default_nettype none
module ceil_divider #(
	parameter int W = 32
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// request
	input wire logic start,
	input wire logic [W-1:0] numer,
	input wire logic [W-1:0] denom,
	// result
	output logic busy,
	output logic done,
	output logic [W-1:0] quot
);
	logic [W-1:0] rem_r, rem_nxt;
	logic [W-1:0] q_r, q_nxt;
	logic [W-1:0] den_r, den_nxt;
	logic [W-1:0] quot_r, quot_nxt;
	logic [$clog2(W+1)-1:0] cnt_r, cnt_nxt;
	logic busy_r, busy_nxt;
	logic done_r, done_nxt;
	logic [W:0] sh;

	always_comb begin
		rem_nxt = rem_r;
		q_nxt = q_r;
		den_nxt = den_r;
		quot_nxt = quot_r;
		cnt_nxt = cnt_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		sh = {rem_r, q_r[W-1]};
		if (busy_r) begin
			if (sh >= {1'b0, den_r}) begin
				rem_nxt = W'(sh - {1'b0, den_r});
				q_nxt = {q_r[W-2:0], 1'b1};
			end else begin
				rem_nxt = sh[W-1:0];
				q_nxt = {q_r[W-2:0], 1'b0};
			end
			cnt_nxt = cnt_r - 1'b1;
			if (cnt_r == 1) begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
				// a partial last unit still costs a whole one
				quot_nxt = q_nxt + W'(rem_nxt != '0);
			end
		end else if (start) begin
			if (denom == '0) begin
				// divide by zero saturates instead of hanging
				quot_nxt = '1;
				done_nxt = 1'b1;
			end else begin
				rem_nxt = '0;
				q_nxt = numer;
				den_nxt = denom;
				cnt_nxt = ($clog2(W+1))'(W);
				busy_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rem_r <= '0;
			q_r <= '0;
			den_r <= '0;
			quot_r <= '0;
			cnt_r <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			rem_r <= rem_nxt;
			q_r <= q_nxt;
			den_r <= den_nxt;
			quot_r <= quot_nxt;
			cnt_r <= cnt_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end

	assign busy = busy_r;
	assign done = done_r;
	assign quot = quot_r;
endmodule : ceil_divider
`default_nettype wire

// File: hdl/acq_trigger_timing.sv
// acquisition sequencing: trigger permit, exposure, readout, transmission timing
`timescale 1ns/100ps
`default_nettype none
`include "acq_timing_cfg.svh"
module acq_trigger_timing #(
	parameter int START_DELAY_NS = `ACQ_START_DELAY_NS,
	parameter int LINE_TIME_NS = `ACQ_LINE_TIME_NS,
	parameter int READ_OVERHEAD_NS = `ACQ_READ_OVERHEAD_NS,
	parameter int PKT_CYC = `ACQ_PKT_CYC,
	parameter int TX_TAIL_CYC = `ACQ_TX_TAIL_CYC,
	parameter int CLK_HZ = `ACQ_CLK_HZ
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// trigger pin
	input wire logic external_frame_trigger,
	// configuration
	input wire logic hw_trigger_enable,
	input wire logic [23:0] exposure_time_us,
	input wire logic [11:0] region_window_height,
	input wire logic trig_filter_en,
	input wire logic [15:0] trig_filter_us,
	input wire logic rate_limit_en,
	input wire logic [23:0] rate_limit_fps,
	input wire logic [23:0] payload_bytes,
	input wire logic [13:0] packet_bytes,
	// output routing
	input wire logic route_we,
	input wire logic [1:0] route_line1_sel,
	input wire logic [1:0] route_line2_sel,
	// signals
	output logic acq_permit_out,
	output logic exposure_window_out,
	output logic readout_active,
	output logic tx_active,
	output logic frame_done,
	output logic out_line1,
	output logic out_line2,
	// status
	output logic [31:0] readout_cycles,
	output logic [31:0] tx_end_cycles
);
	localparam int START_DELAY_CYC = (START_DELAY_NS + `ACQ_CLK_PERIOD_NS - 1) / `ACQ_CLK_PERIOD_NS;
	localparam int LINE_CYC = (LINE_TIME_NS + `ACQ_CLK_PERIOD_NS - 1) / `ACQ_CLK_PERIOD_NS;
	localparam int OVH_CYC = (READ_OVERHEAD_NS + `ACQ_CLK_PERIOD_NS - 1) / `ACQ_CLK_PERIOD_NS;
	// trigger synchroniser; stage one is read only by stage two
	logic trig_s1_r, trig_s2_r, trig_s3_r;
	logic trig_rise;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			trig_s1_r <= 1'b0;
			trig_s2_r <= 1'b0;
			trig_s3_r <= 1'b0;
		end else begin
			trig_s1_r <= external_frame_trigger;
			trig_s2_r <= trig_s1_r;
			trig_s3_r <= trig_s2_r;
		end
	end
	assign trig_rise = trig_s2_r & ~trig_s3_r;

	// derived durations in clock cycles
	logic [31:0] tr_cyc, tb_cyc, tmax_cyc, te_cyc, fill_cyc;
	logic [31:0] exp_cyc, delay_cyc;
	logic [31:0] pkt_cnt, period_cyc;
	logic pkt_done, per_done;

	assign tr_cyc = 32'(region_window_height) * 32'(LINE_CYC) + 32'(OVH_CYC);
	assign tb_cyc = 32'(pkt_cnt * 32'(PKT_CYC));
	assign tmax_cyc = (tb_cyc > tr_cyc) ? tb_cyc : tr_cyc;
	assign te_cyc = tmax_cyc + 32'(TX_TAIL_CYC);
	// sending ends with readout or later, so the buffer never runs dry
	assign fill_cyc = tmax_cyc - tb_cyc;
	assign exp_cyc = 32'(exposure_time_us) * 32'(`ACQ_CYC_PER_US);
	assign delay_cyc = 32'(START_DELAY_CYC)
		+ (trig_filter_en ? 32'(trig_filter_us) * 32'(`ACQ_CYC_PER_US) : 32'h0);

	// dividers run freely so settings changes take effect within a few dozen cycles
	ceil_divider #(.W(32)) u_pkt_div (
		.clk_sys(clk_sys),
		.rst(rst),
		.start(1'b1),
		.numer(32'(payload_bytes)),
		.denom(32'(packet_bytes)),
		.busy(),
		.done(pkt_done),
		.quot(pkt_cnt)
	);

	ceil_divider #(.W(32)) u_rate_div (
		.clk_sys(clk_sys),
		.rst(rst),
		.start(1'b1),
		.numer(32'(CLK_HZ)),
		.denom(32'(rate_limit_fps)),
		.busy(),
		.done(per_done),
		.quot(period_cyc)
	);

	// main acquisition sequence
	acq_timing_pkg::acq_state_t st_r, st_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic [31:0] per_cnt_r, per_cnt_nxt;
	logic [31:0] exp_lat_r, exp_lat_nxt;
	logic permit_r, permit_nxt;
	logic expwin_r, expwin_nxt;
	logic read_start;
	logic period_ok;
	logic tx_ready;
	// an over-high limit simply never binds; readout or sending, whichever ends later, then sets the pace
	assign period_ok = ~rate_limit_en || (rate_limit_fps == 24'h0)
		|| (per_cnt_r >= period_cyc);

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		exp_lat_nxt = exp_lat_r;
		per_cnt_nxt = (per_cnt_r == 32'hFFFFFFFF) ? per_cnt_r : per_cnt_r + 32'h1;
		read_start = 1'b0;
		case (st_r)
			acq_timing_pkg::ST_IDLE: begin
				// edges while permit is low never leave idle
				if (trig_rise && permit_r) begin
					st_nxt = acq_timing_pkg::ST_DELAY;
					cnt_nxt = delay_cyc;
					exp_lat_nxt = exp_cyc;
				end
			end
			acq_timing_pkg::ST_DELAY: begin
				if (cnt_r <= 32'h1) begin
					st_nxt = acq_timing_pkg::ST_EXPOSE;
					cnt_nxt = exp_lat_r;
					per_cnt_nxt = 32'h1;
				end else begin
					cnt_nxt = cnt_r - 32'h1;
				end
			end
			acq_timing_pkg::ST_EXPOSE: begin
				if (cnt_r <= 32'h1) begin
					st_nxt = acq_timing_pkg::ST_READOUT;
					cnt_nxt = tr_cyc;
					read_start = 1'b1;
				end else begin
					cnt_nxt = cnt_r - 32'h1;
				end
			end
			acq_timing_pkg::ST_READOUT: begin
				// no new trigger is taken before readout is over
				if (cnt_r <= 32'h1) begin
					st_nxt = acq_timing_pkg::ST_IDLE;
					cnt_nxt = 32'h0;
				end else begin
					cnt_nxt = cnt_r - 32'h1;
				end
			end
			default: begin
				st_nxt = acq_timing_pkg::ST_IDLE;
				cnt_nxt = 32'h0;
			end
		endcase
		// permit looks one state ahead so it drops the cycle after the accepted edge
		permit_nxt = hw_trigger_enable && (st_nxt == acq_timing_pkg::ST_IDLE)
			&& period_ok && tx_ready;
		expwin_nxt = (st_nxt == acq_timing_pkg::ST_EXPOSE);
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_r <= acq_timing_pkg::ST_IDLE;
			cnt_r <= 32'h0;
			per_cnt_r <= 32'hFFFFFFFF;
			exp_lat_r <= 32'h0;
			permit_r <= 1'b0;
			expwin_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			per_cnt_r <= per_cnt_nxt;
			exp_lat_r <= exp_lat_nxt;
			permit_r <= permit_nxt;
			expwin_r <= expwin_nxt;
		end
	end

	// transmission timing, measured from readout start
	acq_timing_pkg::tx_state_t tx_r, tx_nxt;
	logic [31:0] tx_cnt_r, tx_cnt_nxt;
	logic [31:0] tx_fill_r, tx_fill_nxt;
	logic [31:0] tx_max_r, tx_max_nxt;
	logic [31:0] tx_end_r, tx_end_nxt;
	logic done_r, done_nxt;

	// one frame in the send stage at a time; the tail may overlap the next delay and exposure
	assign tx_ready = (tx_r == acq_timing_pkg::TX_IDLE) || (tx_r == acq_timing_pkg::TX_TAIL);

	always_comb begin
		tx_nxt = tx_r;
		tx_cnt_nxt = tx_cnt_r + 32'h1;
		tx_fill_nxt = tx_fill_r;
		tx_max_nxt = tx_max_r;
		tx_end_nxt = tx_end_r;
		done_nxt = 1'b0;
		case (tx_r)
			acq_timing_pkg::TX_IDLE: begin
				tx_cnt_nxt = 32'h0;
			end
			acq_timing_pkg::TX_FILL: begin
				if (tx_cnt_r + 32'h1 >= tx_fill_r) begin
					tx_nxt = acq_timing_pkg::TX_SEND;
				end
			end
			acq_timing_pkg::TX_SEND: begin
				if (tx_cnt_r + 32'h1 >= tx_max_r) begin
					tx_nxt = acq_timing_pkg::TX_TAIL;
				end
			end
			acq_timing_pkg::TX_TAIL: begin
				if (tx_cnt_r + 32'h1 >= tx_end_r) begin
					tx_nxt = acq_timing_pkg::TX_IDLE;
					tx_cnt_nxt = 32'h0;
					done_nxt = 1'b1;
				end
			end
			default: begin
				tx_nxt = acq_timing_pkg::TX_IDLE;
				tx_cnt_nxt = 32'h0;
			end
		endcase
		// a new readout restarts the timeline; an unfinished tail is cut short
		if (read_start) begin
			tx_nxt = (fill_cyc == 32'h0) ? acq_timing_pkg::TX_SEND : acq_timing_pkg::TX_FILL;
			tx_cnt_nxt = 32'h0;
			tx_fill_nxt = fill_cyc;
			tx_max_nxt = tmax_cyc;
			tx_end_nxt = te_cyc;
			done_nxt = (tx_r == acq_timing_pkg::TX_TAIL);
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_r <= acq_timing_pkg::TX_IDLE;
			tx_cnt_r <= 32'h0;
			tx_fill_r <= 32'h0;
			tx_max_r <= 32'h0;
			tx_end_r <= 32'h0;
			done_r <= 1'b0;
		end else begin
			tx_r <= tx_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			tx_fill_r <= tx_fill_nxt;
			tx_max_r <= tx_max_nxt;
			tx_end_r <= tx_end_nxt;
			done_r <= done_nxt;
		end
	end

	// output line routing
	logic [1:0] sel1_r, sel1_nxt, sel2_r, sel2_nxt;
	logic line1_r, line1_nxt, line2_r, line2_nxt;
	logic read_r, read_nxt, txa_r, txa_nxt;
	logic [31:0] tr_stat_r, te_stat_r;
	function automatic logic route_pick(input logic [1:0] sel, input logic expw,
		input logic perm, input logic txa);
		case (sel)
			`ACQ_ROUTE_EXPOSURE: route_pick = expw;
			`ACQ_ROUTE_PERMIT: route_pick = perm;
			`ACQ_ROUTE_TX: route_pick = txa;
			default: route_pick = 1'b0;
		endcase
	endfunction : route_pick

	always_comb begin
		sel1_nxt = route_we ? route_line1_sel : sel1_r;
		sel2_nxt = route_we ? route_line2_sel : sel2_r;
		read_nxt = (st_nxt == acq_timing_pkg::ST_READOUT);
		txa_nxt = (tx_nxt == acq_timing_pkg::TX_SEND);
		line1_nxt = route_pick(sel1_r, expwin_nxt, permit_nxt, txa_nxt);
		line2_nxt = route_pick(sel2_r, expwin_nxt, permit_nxt, txa_nxt);
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sel1_r <= `ACQ_LINE1_RESET;
			sel2_r <= `ACQ_LINE2_RESET;
			line1_r <= 1'b0;
			line2_r <= 1'b0;
			read_r <= 1'b0;
			txa_r <= 1'b0;
			tr_stat_r <= 32'h0;
			te_stat_r <= 32'h0;
		end else begin
			sel1_r <= sel1_nxt;
			sel2_r <= sel2_nxt;
			line1_r <= line1_nxt;
			line2_r <= line2_nxt;
			read_r <= read_nxt;
			txa_r <= txa_nxt;
			tr_stat_r <= tr_cyc;
			te_stat_r <= te_cyc;
		end
	end

	assign acq_permit_out = permit_r;
	assign exposure_window_out = expwin_r;
	assign readout_active = read_r;
	assign tx_active = txa_r;
	assign frame_done = done_r;
	assign out_line1 = line1_r;
	assign out_line2 = line2_r;
	assign readout_cycles = tr_stat_r;
	assign tx_end_cycles = te_stat_r;
endmodule : acq_trigger_timing
`default_nettype wire

// File: test/acq_trigger_timing_checker.sv
// port-level checks for the acquisition sequencing block
`timescale 1ns/100ps
`default_nettype none
module acq_trigger_timing_checker #(
	parameter int LINE_TIME_NS = 100,
	parameter int READ_OVERHEAD_NS = 1000
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// configuration
	input wire logic hw_trigger_enable,
	input wire logic [23:0] exposure_time_us,
	input wire logic [11:0] region_window_height,
	input wire logic route_we,
	// outputs
	input wire logic acq_permit_out,
	input wire logic exposure_window_out,
	input wire logic readout_active,
	input wire logic tx_active,
	input wire logic out_line1,
	input wire logic out_line2,
	input wire logic [31:0] readout_cycles
);
	logic [31:0] ex_r, ex_nxt, rd_r, rd_nxt, tr;
	logic [1:0] up_r, up_nxt;
	logic moved_r, moved_nxt;
	assign tr = 32'(region_window_height) * 32'((LINE_TIME_NS + 9) / 10)
		+ 32'((READ_OVERHEAD_NS + 9) / 10);
	always_comb begin
		ex_nxt = exposure_window_out ? ex_r + 32'h1 : 32'h0;
		rd_nxt = readout_active ? rd_r + 32'h1 : 32'h0;
		up_nxt = (up_r == 2'h3) ? up_r : up_r + 2'h1;
		moved_nxt = moved_r | route_we;
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ex_r <= 32'h0;
			rd_r <= 32'h0;
			up_r <= 2'h0;
			moved_r <= 1'b0;
		end else begin
			ex_r <= ex_nxt;
			rd_r <= rd_nxt;
			up_r <= up_nxt;
			moved_r <= moved_nxt;
		end
	end
	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_permit_busy: assert property ((exposure_window_out || readout_active) |-> !acq_permit_out)
		else $error("permit high while busy");
	a_no_overlap: assert property (!(exposure_window_out && readout_active))
		else $error("exposure overlaps readout");
	a_hw_disable: assert property (!hw_trigger_enable ##1 !hw_trigger_enable |-> !acq_permit_out)
		else $error("permit while disabled");
	a_readout_start: assert property ($fell(exposure_window_out) |-> ##[0:1] readout_active)
		else $error("readout not started");
	a_exposure_len: assert property ($fell(exposure_window_out) |-> ex_r == 32'(exposure_time_us) * 32'h64)
		else $error("exposure length wrong");
	a_readout_len: assert property ($fell(readout_active) |-> rd_r + 32'h1 >= tr && rd_r <= tr + 32'h1)
		else $error("readout length wrong");
	a_readout_calc: assert property (up_r == 2'h3 && $stable(region_window_height) ##1
		$stable(region_window_height) |-> readout_cycles == tr)
		else $error("readout cycles wrong");
	a_route_default: assert property (!moved_r |-> out_line1 == exposure_window_out &&
		out_line2 == acq_permit_out)
		else $error("default routing wrong");
	a_tx_after_read: assert property ($fell(tx_active) |-> ##1 !readout_active)
		else $error("send ended before readout");
endmodule : acq_trigger_timing_checker
bind acq_trigger_timing acq_trigger_timing_checker #(
	.LINE_TIME_NS(LINE_TIME_NS),
	.READ_OVERHEAD_NS(READ_OVERHEAD_NS)
) chk_i (.clk_sys, .rst, .hw_trigger_enable, .exposure_time_us, .region_window_height,
	.route_we, .acq_permit_out, .exposure_window_out, .readout_active, .tx_active,
	.out_line1, .out_line2, .readout_cycles);
`default_nettype wire

// File: test/trigger_source_model.sv
// external trigger source: fires once the permit is up
`timescale 1ns/100ps
`default_nettype none
module trigger_source_model (
	// clock
	input wire logic clk_sys,
	// control
	input wire logic permit,
	input wire logic go,
	input wire logic [3:0] lag,
	// trigger pin
	output logic trig
);
	int w = 0;
	initial trig = 1'b0;
	// held until permit drops so the synchroniser cannot miss it
	always @(negedge clk_sys) begin
		w <= go && permit && !trig ? w + 1 : 0;
		if (trig && !permit)
			trig <= 1'b0;
		else if (go && permit && w >= lag)
			trig <= 1'b1;
	end
endmodule : trigger_source_model
`default_nettype wire

// File: test/acq_trigger_timing_tb.sv
// self-checking bench for the acquisition sequencing block
`timescale 1ns/100ps
`default_nettype none
module acq_trigger_timing_tb;
	localparam int D = 10, OVH = 100, LN = 10, PK = 10, TL = 20, HZ = 1000000;
	logic clk_sys = 1'b0, rst = 1'b1, en = 1'b1, f_en = 1'b0, l_en = 1'b0, we = 1'b0;
	logic go = 1'b0, tt = 1'b0, st, pin, perm, expw, rda, txa, fd, l1, l2;
	logic [23:0] ex = 24'h1, fps = 24'h0, pay = 24'h64;
	logic [15:0] f_us = 16'h1;
	logic [13:0] pkt = 14'h32;
	logic [11:0] h = 12'h4;
	logic [1:0] s1 = 2'h1, s2 = 2'h2;
	logic [3:0] lag = 4'h0;
	logic [31:0] rcy, tcy;
	int fail_count = 0, n_checks = 0, seed = 32'h5a7e;
	int t = 0, tp = 0, er = 0, rr = 0, nexp = 0, nfd = 0, since = 0, k, tr, tb, mx, per;
	bit fresh = 0;
	assign pin = st | tt;
	trigger_source_model src (.clk_sys(clk_sys), .permit(perm), .go(go), .lag(lag), .trig(st));
	acq_trigger_timing #(.START_DELAY_NS(100), .LINE_TIME_NS(100), .READ_OVERHEAD_NS(1000),
		.PKT_CYC(PK), .TX_TAIL_CYC(TL), .CLK_HZ(HZ)) uut (.clk_sys(clk_sys), .rst(rst),
		.external_frame_trigger(pin), .hw_trigger_enable(en), .exposure_time_us(ex),
		.region_window_height(h), .trig_filter_en(f_en), .trig_filter_us(f_us),
		.rate_limit_en(l_en), .rate_limit_fps(fps), .payload_bytes(pay), .packet_bytes(pkt),
		.route_we(we), .route_line1_sel(s1), .route_line2_sel(s2), .acq_permit_out(perm),
		.exposure_window_out(expw), .readout_active(rda), .tx_active(txa), .frame_done(fd),
		.out_line1(l1), .out_line2(l2), .readout_cycles(rcy), .tx_end_cycles(tcy));
	initial forever #5 clk_sys = ~clk_sys;
	always_comb begin
		tr = h * LN + OVH;
		tb = (pay + pkt - 1) / pkt * PK;
		mx = tr > tb ? tr : tb;
		per = l_en && fps != 0 ? (HZ + fps - 1) / fps : 0;
	end
	task automatic chk(string n, int e, int g, int tol);
		n_checks++;
		if (g < e - tol || g > e + tol) begin
			fail_count++;
			$display("Error %s expected %0d seen %0d", n, e, g);
		end
	endtask : chk
	task automatic cmpv(string n, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : cmpv
	function automatic logic pick(logic [1:0] s);
		return s == 2'h0 ? 1'b0 : s == 2'h1 ? expw : s == 2'h2 ? perm : txa;
	endfunction : pick
	task automatic wt(int n);
		repeat (n) @(negedge clk_sys);
	endtask : wt
	task automatic results;
		if (fail_count == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results
	task automatic run(int n);
		k = nexp + n;
		go = 1'b1;
		for (int i = 0; i < 30000 && nexp < k; i++) wt(1);
		go = 1'b0;
		for (int i = 0; i < 30000 && !(nfd >= k && perm); i++) wt(1);
		wt(20);
		chk("frames", k, nfd, 0);
	endtask : run
	// timing measured from sampled edges; tolerances absorb registration lag
	always @(posedge clk_sys) begin
		t++;
		since++;
		if (rst)
			fresh = 0;
		else begin
			if ($rose(pin) && perm)
				tp = t;
			if ($rose(expw)) begin
				nexp++;
				er = t;
				chk("delay", D + 3 + (f_en ? 100 * f_us : 0), t - tp, 2);
			end
			if ($fell(expw))
				chk("exposure", 100 * ex, t - er, 0);
			if ($rose(rda))
				rr = t;
			if ($fell(rda)) begin
				fresh = 1;
				chk("readout", tr, t - rr, 1);
			end
			if ($rose(txa))
				chk("tx start", mx - tb, t - rr, 2);
			if (fd) begin
				nfd++;
				chk("frame end", mx + TL, t - rr, 2);
			end
			if ($rose(perm) && fresh) begin
				fresh = 0;
				chk("permit", rr + mx > er + per ? rr + mx : er + per, t, 2);
			end
			if (since > 3) begin
				cmpv("line1", 32'(pick(s1)), 32'(l1));
				cmpv("line2", 32'(pick(s2)), 32'(l2));
			end
		end
	end
	initial begin
		wt(16);
		rst = 1'b0;
		wt(3);
		cmpv("permit", 32'h1, 32'(perm));
		for (int i = 0; i < 4; i++) begin
			h = i == 3 ? 12'($random(seed) & 7) : 12'(4 >> i);
			ex = i == 1 ? 24'h2 : 24'h1;
			f_en = i[0];
			// zero limit, binding limit, disabled limit, over-high limit
			l_en = i != 2;
			fps = i == 1 ? 24'h7D0 : i == 0 ? 24'h0 : 24'h186A0;
			pay = i == 2 ? 24'h3E8 : i == 3 ? 24'(1 + ($random(seed) & 255)) : 24'h64;
			pkt = i == 2 ? 14'h7 : i == 3 ? 14'(1 + ($random(seed) & 63)) : 14'h32;
			lag = 4'($random(seed) & 3);
			s1 = 2'(i);
			s2 = 2'(3 - i);
			we = 1'b1;
			since = 0;
			wt(1);
			we = 1'b0;
			wt(100);
			cmpv("readout cycles", 32'(tr), rcy);
			cmpv("tx end cycles", 32'(mx + TL), tcy);
			run(3);
		end
		k = nexp + 1;
		tt = 1'b1;
		wt(6);
		tt = 1'b0;
		wt(4);
		tt = 1'b1; // lands while permit is low
		wt(3);
		tt = 1'b0;
		for (int i = 0; i < 30000 && !(nfd >= k && perm); i++) wt(1);
		wt(20);
		chk("dropped trigger", k, nexp, 0);
		en = 1'b0;
		wt(3);
		cmpv("permit disabled", 32'h0, 32'(perm));
		tt = 1'b1;
		wt(4);
		tt = 1'b0;
		wt(50);
		chk("disabled trigger", k, nexp, 0);
		en = 1'b1;
		rst = 1'b1;
		s1 = 2'h1;
		s2 = 2'h2;
		since = 0;
		wt(16);
		rst = 1'b0;
		wt(3);
		cmpv("permit after reset", 32'h1, 32'(perm));
		run(1);
		results;
	end
	initial begin
		repeat (60000) @(posedge clk_sys);
		fail_count++;
		results;
	end
endmodule : acq_trigger_timing_tb
`default_nettype wire
